/* pkg/msr_pkg.sv */
// ****************************************************************
// shared constants and types for the setpoint relay controller
// ****************************************************************
package msr_pkg;

  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int BAUD_1200 = 1200;
  localparam int BAUD_2400 = 2400;
  localparam int BAUD_4800 = 4800;
  localparam int BAUD_9600 = 9600;
  localparam logic [16:0] DIV_1200 = 17'(CLK_HZ / BAUD_1200);
  localparam logic [16:0] DIV_2400 = 17'(CLK_HZ / BAUD_2400);
  localparam logic [16:0] DIV_4800 = 17'(CLK_HZ / BAUD_4800);
  localparam logic [16:0] DIV_9600 = 17'(CLK_HZ / BAUD_9600);
  // frame end: 3.5 characters of 11 bits of silence
  localparam logic [5:0] GAP_BITS = 6'h26;

  // function and exception codes
  localparam logic [7:0] FC_READ = 8'h04;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;

  // register map
  localparam logic [15:0] REG_PV = 16'h0000;
  localparam logic [15:0] REG_SP1 = 16'h0001;
  localparam logic [15:0] REG_LAST = 16'h0004;
  localparam logic [16:0] NUM_REGS = 17'h0_0005;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam int NUM_CHAN = 4;

  // crc and frame buffer
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int RX_DEPTH = 32;
  localparam logic [5:0] LEN_READ = 6'h08;
  localparam logic [5:0] LEN_WR_BASE = 6'h09;
  localparam logic [5:0] LEN_MIN = 6'h04;

  typedef enum logic [1:0] {SPD_1200 = 2'b00, SPD_2400 = 2'b01, SPD_4800 = 2'b10,
    SPD_9600 = 2'b11} msr_baud_e;
  typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_ODD = 2'b01, PAR_EVEN = 2'b10} msr_parity_e;
  // gray-coded frame states
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RECV = 2'b01, ST_EXEC = 2'b11,
    ST_SEND = 2'b10} msr_state_e;

  typedef struct packed {
    logic [7:0] station_addr;
    msr_baud_e baud;
    msr_parity_e parity;
  } msr_link_cfg_s;

  typedef struct packed {
    logic relay_sense;
    logic [15:0] switch_gap;
  } msr_chan_cfg_s;

endpackage : msr_pkg

/* verilog/msr_ctrl.sv */
// How it works
// - answer only own station address 1..247
// - bit rate 1200/2400/4800/9600 selectable
// - parity odd, even or none selectable
// - eight data bits, one stop bit
// - read 04: count byte, words high first
// - write 16: echo start/count, store words
// - unknown function gives exception 01
// - start address outside map gives 02
// - bad quantity or length gives 03
// - exception: address, function, code, crc
// - reading at 0, setpoints at 1..4
// - high sense: relay on below setpoint
// - low sense: relay on above setpoint
// - hysteresis gap per channel, both senses
// - relay held for on-delay after change
// - on-delay wins over threshold crossings
// - four relays with status indicators
`timescale 1ns/10ps
`default_nettype none
module msr_ctrl #(
  parameter int MS_CYCLES = msr_pkg::MS_CYC,
  parameter int CLK_HZ_P = msr_pkg::CLK_HZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // configuration
  input wire msr_pkg::msr_link_cfg_s link_cfg,
  input wire msr_pkg::msr_chan_cfg_s chan_cfg [msr_pkg::NUM_CHAN],
  input wire logic [15:0] on_delay_ms,
  input wire logic [15:0] process_reading,
  // serial line
  input wire logic rxd,
  output logic txd,
  output logic tx_drive_en,
  // relay outputs
  output logic [3:0] relay_on,
  output logic [3:0] relay_led,
  output logic [3:0][15:0] target_level
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ msr_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  function automatic logic par_bit(input logic [7:0] d, input msr_pkg::msr_parity_e p);
    return (p == msr_pkg::PAR_ODD) ? ~(^d) : (^d);
  endfunction : par_bit

  // ****************************************************************
  // bit timing
  // ****************************************************************
  // divisors follow the clock parameter, so a slow nominal bench clock keeps frames short
  localparam logic [16:0] DIV_1200_P = 17'(CLK_HZ_P / msr_pkg::BAUD_1200);
  localparam logic [16:0] DIV_2400_P = 17'(CLK_HZ_P / msr_pkg::BAUD_2400);
  localparam logic [16:0] DIV_4800_P = 17'(CLK_HZ_P / msr_pkg::BAUD_4800);
  localparam logic [16:0] DIV_9600_P = 17'(CLK_HZ_P / msr_pkg::BAUD_9600);
  logic [16:0] div_w;
  logic use_par_w;
  logic [3:0] nbits_w;
  assign div_w = (link_cfg.baud == msr_pkg::SPD_1200) ? DIV_1200_P :
                 (link_cfg.baud == msr_pkg::SPD_2400) ? DIV_2400_P :
                 (link_cfg.baud == msr_pkg::SPD_4800) ? DIV_4800_P :
                 DIV_9600_P;
  assign use_par_w = (link_cfg.parity != msr_pkg::PAR_NONE);
  assign nbits_w = use_par_w ? 4'h9 : 4'h8; // bits after start, minus one

  logic [16:0] tick_cnt_r;
  logic bit_tick;
  assign bit_tick = (tick_cnt_r == 17'h0_0000);

  // free running bit-rate enable for transmit and gap timing
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      tick_cnt_r <= 17'h0_0000;
    else
      tick_cnt_r <= bit_tick ? div_w - 17'h0_0001 : tick_cnt_r - 17'h0_0001;
  end

  // ****************************************************************
  // character receiver
  // ****************************************************************
  msr_pkg::msr_state_e st_r;
  logic rx_busy_r;
  logic [16:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [9:0] rx_sh_r;
  logic rx_v_r;
  logic rx_ok_r;
  logic [7:0] rx_byte_r;
  logic [9:0] rx_shn_w;
  logic [7:0] rx_data_w;
  logic rx_last_w;
  logic rx_sample_w;

  assign rx_sample_w = rx_busy_r && (rx_cnt_r == 17'h0_0000);
  assign rx_shn_w = {rxd, rx_sh_r[9:1]};
  assign rx_last_w = rx_sample_w && (rx_bit_r == nbits_w + 4'h1);
  assign rx_data_w = use_par_w ? rx_shn_w[7:0] : rx_shn_w[8:1];

  // sample mid-bit; start bit re-checked to reject glitches
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 17'h0_0000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 10'h3FF;
      rx_v_r <= 1'b0;
      rx_ok_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end
    else
    begin
      rx_v_r <= 1'b0;
      if (!rx_busy_r)
      begin
        if (!rxd && st_r != msr_pkg::ST_SEND)
        begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= div_w >> 1;
          rx_bit_r <= 4'h0;
        end
      end
      else if (rx_sample_w)
      begin
        rx_cnt_r <= div_w - 17'h0_0001;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0)
          rx_busy_r <= !rxd;
        else
          rx_sh_r <= rx_shn_w;
        if (rx_last_w)
        begin
          rx_busy_r <= 1'b0;
          rx_v_r <= 1'b1;
          rx_byte_r <= rx_data_w;
          // stop bit high and parity matching
          rx_ok_r <= rxd && (!use_par_w ||
            par_bit(rx_data_w, link_cfg.parity) == rx_shn_w[8]);
        end
      end
      else
        rx_cnt_r <= rx_cnt_r - 17'h0_0001;
    end
  end

  // ****************************************************************
  // frame capture
  // ****************************************************************
  logic [7:0] buf_r [msr_pkg::RX_DEPTH];
  logic [5:0] len_r;
  logic [15:0] crc_r;
  logic bad_r;
  logic [5:0] gap_r;
  logic frame_end_w;
  assign frame_end_w = (st_r == msr_pkg::ST_RECV) && (gap_r == msr_pkg::GAP_BITS);

  // silence counter in bit times; any character activity restarts it
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      gap_r <= 6'h00;
    else if (rx_busy_r || st_r != msr_pkg::ST_RECV)
      gap_r <= 6'h00;
    else if (bit_tick && gap_r != msr_pkg::GAP_BITS)
      gap_r <= gap_r + 6'h01;
  end

  // request decode
  logic [7:0] fc_w;
  logic [15:0] start_w;
  logic [15:0] qty_w;
  logic [16:0] span_w;
  logic [7:0] bc_w;
  logic frame_ok_w;
  logic qty_bad_w;
  logic start_bad_w;
  logic [7:0] exc_w;
  assign fc_w = buf_r[1];
  assign start_w = {buf_r[2], buf_r[3]};
  assign qty_w = {buf_r[4], buf_r[5]};
  assign bc_w = buf_r[6];
  assign span_w = {1'b0, start_w} + {1'b0, qty_w};
  assign frame_ok_w = !bad_r && len_r >= msr_pkg::LEN_MIN && crc_r == 16'h0000 &&
    buf_r[0] == link_cfg.station_addr && link_cfg.station_addr >= msr_pkg::ADDR_MIN &&
    link_cfg.station_addr <= msr_pkg::ADDR_MAX;
  assign qty_bad_w = (qty_w == 16'h0000) || ({1'b0, qty_w} > msr_pkg::NUM_REGS) ||
    ((fc_w == msr_pkg::FC_READ) ? (len_r != msr_pkg::LEN_READ) :
     ({2'b00, qty_w[6:0], 1'b0} != {2'b00, bc_w} ||
      {2'b00, len_r} != {2'b00, msr_pkg::LEN_WR_BASE} + {2'b00, bc_w}));
  assign start_bad_w = (start_w > msr_pkg::REG_LAST) || (span_w > msr_pkg::NUM_REGS) ||
    (fc_w == msr_pkg::FC_WRITE && start_w == msr_pkg::REG_PV);
  assign exc_w = (fc_w != msr_pkg::FC_READ && fc_w != msr_pkg::FC_WRITE) ? msr_pkg::EXC_FUNC :
                 qty_bad_w ? msr_pkg::EXC_DATA :
                 start_bad_w ? msr_pkg::EXC_ADDR : 8'h00;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  logic [7:0] exc_r;
  logic [5:0] tx_len_r;
  logic [5:0] tx_idx_r;
  logic [15:0] tx_crc_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_bits_r;
  logic [7:0] tx_byte_w;
  logic [7:0] tx_out_w;
  logic [4:0] rd_off_w;
  logic [15:0] rd_word_w;
  logic [15:0] sp_r [msr_pkg::NUM_CHAN];
  logic tx_load_w;
  logic tx_done_w;

  assign rd_off_w = 5'(tx_idx_r - 6'h03);
  assign rd_word_w = (start_w[2:0] + 3'(rd_off_w >> 1) == 3'h0) ? process_reading :
    sp_r[2'(start_w[2:0] + 3'(rd_off_w >> 1) - 3'h1)];
  assign tx_byte_w = (tx_idx_r == 6'h00) ? buf_r[0] :
    (tx_idx_r == 6'h01) ? (exc_r != 8'h00 ? fc_w | msr_pkg::EXC_FLAG : fc_w) :
    (exc_r != 8'h00) ? exc_r :
    (fc_w == msr_pkg::FC_WRITE) ? buf_r[5'(tx_idx_r)] :
    (tx_idx_r == 6'h02) ? {qty_w[6:0], 1'b0} :
    (rd_off_w[0] ? rd_word_w[7:0] : rd_word_w[15:8]);
  assign tx_out_w = (tx_idx_r < tx_len_r) ? tx_byte_w :
    (tx_idx_r == tx_len_r) ? tx_crc_r[7:0] : tx_crc_r[15:8]; // crc low first
  assign tx_load_w = (st_r == msr_pkg::ST_SEND) && bit_tick && tx_bits_r == 4'h0 &&
    tx_idx_r != tx_len_r + 6'h02;
  assign tx_done_w = (st_r == msr_pkg::ST_SEND) && bit_tick && tx_bits_r == 4'h0 &&
    tx_idx_r == tx_len_r + 6'h02;

  // capture, execute and answer; receiver is gated off while sending
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= msr_pkg::ST_IDLE;
      len_r <= 6'h00;
      crc_r <= msr_pkg::CRC_INIT;
      bad_r <= 1'b0;
      exc_r <= 8'h00;
      tx_len_r <= 6'h00;
    end
    else
    begin
      case (st_r)
        msr_pkg::ST_IDLE:
          if (rx_v_r)
          begin
            st_r <= msr_pkg::ST_RECV;
            len_r <= 6'h01;
            crc_r <= crc_step(msr_pkg::CRC_INIT, rx_byte_r);
            bad_r <= !rx_ok_r;
          end
        msr_pkg::ST_RECV:
          if (frame_end_w)
            st_r <= msr_pkg::ST_EXEC;
          else if (rx_v_r)
          begin
            len_r <= (len_r == 6'(msr_pkg::RX_DEPTH)) ? len_r : len_r + 6'h01;
            crc_r <= crc_step(crc_r, rx_byte_r);
            bad_r <= bad_r || !rx_ok_r || len_r == 6'(msr_pkg::RX_DEPTH);
          end
        msr_pkg::ST_EXEC:
        begin
          exc_r <= exc_w;
          tx_len_r <= (exc_w != 8'h00) ? 6'h03 :
            (fc_w == msr_pkg::FC_WRITE) ? 6'h06 : 6'h03 + {qty_w[4:0], 1'b0};
          st_r <= frame_ok_w ? msr_pkg::ST_SEND : msr_pkg::ST_IDLE;
        end
        msr_pkg::ST_SEND:
          if (tx_done_w)
            st_r <= msr_pkg::ST_IDLE;
        default:
          st_r <= msr_pkg::ST_IDLE;
      endcase
    end
  end

  // frame bytes are stored by plain write port
  always_ff @(posedge core_clk)
  begin
    if (rx_v_r && (st_r == msr_pkg::ST_IDLE || (st_r == msr_pkg::ST_RECV &&
        len_r < 6'(msr_pkg::RX_DEPTH))))
      buf_r[(st_r == msr_pkg::ST_IDLE) ? 5'h00 : len_r[4:0]] <= rx_byte_r;
  end

  // ****************************************************************
  // character transmitter
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_sh_r <= 11'h7FF;
      tx_bits_r <= 4'h0;
      tx_idx_r <= 6'h00;
      tx_crc_r <= msr_pkg::CRC_INIT;
    end
    else if (st_r != msr_pkg::ST_SEND)
    begin
      tx_idx_r <= 6'h00;
      tx_crc_r <= msr_pkg::CRC_INIT;
      tx_sh_r <= 11'h7FF;
    end
    else if (tx_load_w)
    begin
      // start, data lsb first, optional parity, stop
      tx_sh_r <= use_par_w ? {1'b1, par_bit(tx_out_w, link_cfg.parity), tx_out_w, 1'b0} :
        {2'b11, tx_out_w, 1'b0};
      tx_bits_r <= nbits_w + 4'h1;
      tx_idx_r <= tx_idx_r + 6'h01;
      if (tx_idx_r < tx_len_r)
        tx_crc_r <= crc_step(tx_crc_r, tx_out_w);
    end
    else if (bit_tick && tx_bits_r != 4'h0)
    begin
      tx_sh_r <= {1'b1, tx_sh_r[10:1]};
      tx_bits_r <= tx_bits_r - 4'h1;
    end
  end

  assign txd = tx_sh_r[0];
  assign tx_drive_en = (st_r == msr_pkg::ST_SEND);

  // ****************************************************************
  // setpoint registers and relay channels
  // ****************************************************************
  logic [16:0] ms_cnt_r;
  logic ms_tick;
  assign ms_tick = (ms_cnt_r == 17'(MS_CYCLES - 1));

  // millisecond enable for the on-delay hold
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      ms_cnt_r <= 17'h0_0000;
    else
      ms_cnt_r <= ms_tick ? 17'h0_0000 : ms_cnt_r + 17'h0_0001;
  end

  logic [15:0] hold_r [msr_pkg::NUM_CHAN];
  logic [3:0] want_on_w;

  for (genvar g = 0; g < msr_pkg::NUM_CHAN; g++)
  begin : g_chan
    logic [15:0] gidx_w;
    logic wr_hit_w;
    logic [4:0] wr_pos_w;
    logic [16:0] pv_gap_w;
    logic [16:0] sp_gap_w;
    assign gidx_w = 16'(g) + msr_pkg::REG_SP1;
    assign wr_hit_w = (st_r == msr_pkg::ST_EXEC) && frame_ok_w && exc_w == 8'h00 &&
      fc_w == msr_pkg::FC_WRITE && gidx_w >= start_w && {1'b0, gidx_w} < span_w;
    assign wr_pos_w = 5'h07 + {gidx_w[3:0] - start_w[3:0], 1'b0};
    assign pv_gap_w = {1'b0, process_reading} + {1'b0, chan_cfg[g].switch_gap};
    assign sp_gap_w = {1'b0, sp_r[g]} + {1'b0, chan_cfg[g].switch_gap};
    // off at the setpoint, back on only beyond the gap
    assign want_on_w[g] = chan_cfg[g].relay_sense ?
      (relay_on[g] ? process_reading < sp_r[g] : pv_gap_w < {1'b0, sp_r[g]}) :
      (relay_on[g] ? process_reading > sp_r[g] : {1'b0, process_reading} > sp_gap_w);

    // setpoint store, high byte first
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
        sp_r[g] <= msr_pkg::SP_RESET;
      else if (wr_hit_w)
        sp_r[g] <= {buf_r[wr_pos_w], buf_r[wr_pos_w + 5'h01]};
    end

    // relay changes only with the hold expired
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        relay_on[g] <= 1'b0;
        hold_r[g] <= 16'h0000;
      end
      else if (hold_r[g] != 16'h0000)
        hold_r[g] <= ms_tick ? hold_r[g] - 16'h0001 : hold_r[g];
      else if (want_on_w[g] != relay_on[g])
      begin
        relay_on[g] <= want_on_w[g];
        hold_r[g] <= on_delay_ms;
      end
    end

    assign target_level[g] = sp_r[g];
  end

  assign relay_led = relay_on;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic [16:0] pv_gap_chk;
  assign pv_gap_chk = {1'b0, process_reading} + {1'b0, chan_cfg[0].switch_gap};

  a_hold_blocks_change: assert property ((hold_r[0] != 16'h0000) |=>
    $stable(relay_on[0]))
    else $error("relay 0 changed during hold");
  a_change_loads_hold: assert property ($changed(relay_on[1]) |->
    hold_r[1] == $past(on_delay_ms))
    else $error("relay 1 hold not loaded");
  a_high_sense_off: assert property ((chan_cfg[2].relay_sense && relay_on[2] &&
    hold_r[2] == 16'h0000 && process_reading >= sp_r[2]) |=> !relay_on[2])
    else $error("high sense relay not released");
  a_low_sense_off: assert property ((!chan_cfg[3].relay_sense && relay_on[3] &&
    hold_r[3] == 16'h0000 && process_reading <= sp_r[3]) |=> !relay_on[3])
    else $error("low sense relay not released");
  a_gap_keeps_off: assert property ((chan_cfg[0].relay_sense && !relay_on[0] &&
    pv_gap_chk >= {1'b0, sp_r[0]}) |=> !relay_on[0])
    else $error("relay 0 on inside gap");
  a_foreign_silent: assert property ((st_r == msr_pkg::ST_EXEC &&
    buf_r[0] != link_cfg.station_addr) |=> st_r == msr_pkg::ST_IDLE)
    else $error("reply to foreign address");
  a_bad_crc_silent: assert property ((st_r == msr_pkg::ST_EXEC && crc_r != 16'h0000)
    |=> !tx_drive_en [*2])
    else $error("reply to bad crc frame");
  a_unknown_func: assert property ((st_r == msr_pkg::ST_EXEC && frame_ok_w &&
    fc_w != msr_pkg::FC_READ && fc_w != msr_pkg::FC_WRITE) |=> exc_r == msr_pkg::EXC_FUNC &&
    tx_len_r == 6'h03)
    else $error("exception 01 not issued");
  a_idle_line_high: assert property (!tx_drive_en |-> txd)
    else $error("line driven low while idle");
  a_led_follows: assert property (relay_led == relay_on)
    else $error("indicator differs from relay");

  c_reply_sent: cover property (tx_done_w && exc_r == 8'h00);
  c_exception_sent: cover property (tx_done_w && exc_r == msr_pkg::EXC_ADDR);
  c_setpoint_write: cover property (g_chan[0].wr_hit_w);
  c_relay_toggle: cover property ($rose(relay_on[0]));

endmodule : msr_ctrl
`default_nettype wire

/* verification/msr_master.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// modbus master on the far side of the line
// ****************************************
module msr_master #(
  parameter int BIT_CYC = 13020,
  parameter int PAR = 2
) (
  // clock
  input wire logic core_clk,
  // serial line
  output logic rxd,
  input wire logic txd,
  output logic line_err
);
  // line idles high through the bus bias
  initial rxd = 1'b1;
  initial line_err = 1'b0;

  // crc: all ones start, reflected poly, lsb first
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = msr_pkg::CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ msr_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc16

  // one bit time, changed on the falling edge
  task automatic put_bit(input logic b);
    @(negedge core_clk);
    rxd <= b;
    repeat (BIT_CYC - 1) @(negedge core_clk);
  endtask : put_bit

  // whole frame, crc low byte first; bad corrupts the crc
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      put_bit(1'b0);
      for (int k = 0; k < 8; k++) put_bit(q[i][k]);
      if (PAR != 0) put_bit(^q[i] ^ (PAR == 1));
      put_bit(1'b1);
    end
  endtask : send

  // reply chars sampled mid-bit; two quiet bit times end the frame
  task automatic recv(output logic [7:0] q[$], input int wait_bits);
    int n;
    logic [7:0] b;
    q = {};
    n = wait_bits * BIT_CYC;
    while (n > 0)
    begin
      @(posedge core_clk);
      n--;
      if (txd === 1'b0)
      begin
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int k = 0; k < 8; k++)
        begin
          repeat (BIT_CYC) @(posedge core_clk);
          b[k] = txd;
        end
        repeat (BIT_CYC) @(posedge core_clk);
        if (PAR != 0 && txd !== (^b ^ (PAR == 1))) line_err = 1'b1;
        if (PAR != 0) repeat (BIT_CYC) @(posedge core_clk);
        if (txd !== 1'b1) line_err = 1'b1;
        q.push_back(b);
        n = 2 * BIT_CYC;
      end
    end
    // master keeps the frame gap before its next request
    if (q.size() > 0) repeat (40 * BIT_CYC) @(posedge core_clk);
  endtask : recv
endmodule : msr_master
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// self-checking bench for the relay controller
// ****************************************
module testbench;
  // design sees a slow nominal clock, so one bit lasts 16 cycles and the run stays short
  localparam int CLK_P = 153_600;
  localparam int BIT = CLK_P / msr_pkg::BAUD_9600;
  localparam int LIMIT = 60_000;
  localparam logic [7:0] STN = 8'h11;
  logic core_clk;
  logic rst_b;
  logic rxd;
  logic txd;
  logic tx_drive_en;
  logic line_err;
  msr_pkg::msr_link_cfg_s link_cfg;
  msr_pkg::msr_chan_cfg_s chan_cfg [msr_pkg::NUM_CHAN];
  logic [15:0] on_delay_ms;
  logic [15:0] process_reading;
  logic [3:0] relay_on;
  logic [3:0] relay_led;
  logic [3:0][15:0] target_level;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int sp [4];
  logic [3:0] exp_rl;
  logic [7:0] req[$];
  logic [7:0] rsp[$];

  msr_ctrl #(.MS_CYCLES(10), .CLK_HZ_P(CLK_P)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .link_cfg(link_cfg),
    .chan_cfg(chan_cfg), .on_delay_ms(on_delay_ms), .process_reading(process_reading),
    .rxd(rxd), .txd(txd), .tx_drive_en(tx_drive_en), .relay_on(relay_on),
    .relay_led(relay_led), .target_level(target_level));
  msr_master #(.BIT_CYC(BIT), .PAR(2)) master (.core_clk(core_clk), .rxd(rxd), .txd(txd),
    .line_err(line_err));

  // 8 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("counts: compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_relay(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_relay

  // one request, whole reply against the model frame
  task automatic xfer(input logic bad);
    logic [7:0] got[$];
    logic [15:0] c;
    if (rsp.size() > 0)
    begin
      c = master.crc16(rsp);
      rsp.push_back(c[7:0]);
      rsp.push_back(c[15:8]);
    end
    master.send(req, bad);
    master.recv(got, 80);
    chk_word("reply_len", 16'(rsp.size()), 16'(got.size()));
    foreach (rsp[i])
      if (i < got.size()) chk_word("reply_byte", {8'h00, rsp[i]}, {8'h00, got[i]});
    chk_word("line_err", 16'h0000, {15'h0000, line_err});
    chk_word("drive_idle", 16'h0000, {15'h0000, tx_drive_en});
  endtask : xfer

  // relay model: off at setpoint, on past the gap, else keep
  function automatic logic rl_one(input logic s, input int g, input int t, input int rd,
    input logic pv);
    if (s) return (rd >= t) ? 1'b0 : (rd + g < t) ? 1'b1 : pv;
    return (rd <= t) ? 1'b0 : (rd > t + g) ? 1'b1 : pv;
  endfunction : rl_one

  task automatic step(input int rd, input int w);
    @(negedge core_clk);
    process_reading = 16'(rd);
    for (int i = 0; i < 4; i++)
      exp_rl[i] = rl_one(chan_cfg[i].relay_sense, int'(chan_cfg[i].switch_gap), sp[i], rd,
        exp_rl[i]);
    repeat (w) @(negedge core_clk);
  endtask : step

  // main sequence
  initial
  begin
    void'($urandom(32'h2a0b));
    rst_b = 1'b0;
    link_cfg = '{station_addr: STN, baud: msr_pkg::SPD_9600, parity: msr_pkg::PAR_EVEN};
    chan_cfg[0] = '{1'b1, 16'h0005};
    chan_cfg[1] = '{1'b0, 16'h0005};
    chan_cfg[2] = '{1'b1, 16'h0000};
    chan_cfg[3] = '{1'b0, 16'h0014};
    on_delay_ms = 16'h0000;
    process_reading = 16'h1234;
    exp_rl = 4'h0;
    repeat (6) @(negedge core_clk);
    rst_b = 1'b1;
    chk_word("txd_idle", 16'h0001, {15'h0000, txd});
    chk_relay("relay_reset", 4'h0, relay_on);
    foreach (sp[i]) chk_word("setpoint_reset", 16'h0000, target_level[i]);
    $display("test reset done");
    // write all four setpoints
    foreach (sp[i]) sp[i] = 1000 + int'($urandom % 8);
    req = {STN, msr_pkg::FC_WRITE, 8'h00, 8'h01, 8'h00, 8'h04, 8'h08};
    foreach (sp[i]) req = {req, 8'(sp[i] >> 8), 8'(sp[i])};
    rsp = {STN, msr_pkg::FC_WRITE, 8'h00, 8'h01, 8'h00, 8'h04};
    xfer(1'b0);
    foreach (sp[i]) chk_word("setpoint", 16'(sp[i]), target_level[i]);
    $display("test write done");
    // read the whole map
    req = {STN, msr_pkg::FC_READ, 8'h00, 8'h00, 8'h00, 8'h05};
    rsp = {STN, msr_pkg::FC_READ, 8'h0A, 8'h12, 8'h34};
    foreach (sp[i]) rsp = {rsp, 8'(sp[i] >> 8), 8'(sp[i])};
    xfer(1'b0);
    $display("test read done");
    // bad function, start past the map, zero quantity
    for (int k = 1; k <= 3; k++)
    begin
      req = {STN, (k == 1) ? 8'h03 : msr_pkg::FC_READ, 8'h00, (k == 2) ? 8'h05 : 8'h00,
        8'h00, (k == 3) ? 8'h00 : 8'h01};
      rsp = {STN, req[1] | msr_pkg::EXC_FLAG, 8'(k)};
      xfer(1'b0);
    end
    $display("test exception done");
    // foreign station, then a corrupted crc: both stay silent
    for (int k = 0; k < 2; k++)
    begin
      req = {STN + 8'(1 - k), msr_pkg::FC_READ, 8'h00, 8'h00, 8'h00, 8'h01};
      rsp = {};
      xfer(k == 1);
    end
    $display("test silent done");
    // random sweep around the setpoints, no hold
    step(2000, 4);
    for (int n = 0; n < 30; n++)
    begin
      step(980 + int'($urandom % 50), 4);
      chk_relay("relay_on", exp_rl, relay_on);
      chk_relay("relay_led", exp_rl, relay_led);
    end
    $display("test sweep done");
    // 2 ms hold: a crossing inside it must wait
    @(negedge core_clk);
    on_delay_ms = 16'h0002;
    step(900, 40);
    step(1100, 4);
    chk_relay("relay_flip", exp_rl, relay_on);
    // hold of 2 ms lasts at least 11 cycles; look well inside it
    step(900, 4);
    chk_relay("relay_held", ~exp_rl, relay_on);
    repeat (40) @(negedge core_clk);
    chk_relay("relay_release", exp_rl, relay_on);
    $display("test hold done");
    close_out();
  end
endmodule : testbench
`default_nettype wire
